// ===== hdl/bfpa_pkg.sv
// Purpose: shared constants and types for the boot flash protection block
// Assumes: 64K byte program space, 32K words, single clock
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package bfpa_pkg;
   // ***************************************************
   // bus geometry
   // ***************************************************
   localparam int BFPA_ADDR_W = 8;
   localparam int BFPA_DATA_W = 32;
   localparam logic [1:0] BFPA_RESP_OKAY = 2'h0;
   localparam logic [1:0] BFPA_RESP_DECERR = 2'h3;
   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [7:0] BFPA_OFF_PTR_LOW = 8'h00;
   localparam logic [7:0] BFPA_OFF_PTR_HIGH = 8'h04;
   localparam logic [7:0] BFPA_OFF_PTR_EXT = 8'h08;
   localparam logic [7:0] BFPA_OFF_GUARD = 8'h0C;
   localparam logic [7:0] BFPA_OFF_LOCK = 8'h10;
   localparam logic [7:0] BFPA_OFF_STATUS = 8'h14;
   localparam logic [7:0] BFPA_OFF_PROG_ADDR = 8'h18;
   // ***************************************************
   // field layout
   // ***************************************************
   localparam int BFPA_GUARD_APP_LSB = 0; // app_guard_low at 0, app_guard_high at 1
   localparam int BFPA_GUARD_BOOT_LSB = 2; // boot_guard_low at 2, boot_guard_high at 3
   localparam int BFPA_ST_FUSE = 0;
   localparam int BFPA_ST_RESULT_LSB = 4;
   // ***************************************************
   // flash geometry
   // ***************************************************
   localparam int BFPA_WORD_W = 15; // word address width
   localparam int BFPA_PAGE_WORD_W = 7; // word_in_page_index width
   localparam int BFPA_PAGE_W = BFPA_WORD_W - BFPA_PAGE_WORD_W;
   localparam bit BFPA_HAS_EXT = 1'b0; // extension used only above 64K bytes
   localparam logic [14:0] BFPA_LOADER_START = 15'h7000; // loader_section first word
   localparam logic [14:0] BFPA_APP_RESET = 15'h0000;
   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [7:0] BFPA_PTR_RST = 8'h00;
   localparam logic [1:0] BFPA_FIELD_RST = 2'h3; // unprogrammed
   localparam logic BFPA_FUSE_RST = 1'b1; // unprogrammed
   // ***************************************************
   // types
   // ***************************************************
   typedef enum logic [1:0] {BFPA_RES_NONE, BFPA_RES_OK, BFPA_RES_DENIED} bfpa_res_t;
endpackage

// ===== hdl/bfpa_top.sv
// Purpose: flash access guard, reset vector select and pointer split
// Assumes: core requests are one-cycle pulses synchronous to clk
// Notes: decisions appear one cycle after the request pulse
`timescale 1ns/1ps

// Operation
// - guards programmable, cleared only by erase
// - write lock never blocks self program
// - read/write lock never blocks load/store
// - app mode 1 allows all access
// - app modes 2,3 refuse app writes
// - app modes 3,4 refuse loader reads
// - app modes 3,4 mask irq in app when vectors sit in loader
// - boot mode 1 allows all access
// - boot modes 2,3 refuse loader writes
// - boot modes 3,4 refuse app reads
// - boot modes 3,4 mask irq in loader when vectors sit in app
// - fuse unprogrammed gives vector zero
// - fuse programmed gives loader start vector
// - only external port changes the fuse
// - pointer from two bytes, extension above 64K
// - low bits word, high bits page
// - capture address when programming starts
// - load uses byte address, bit zero selects
// - self program from app is refused
module bfpa_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [bfpa_pkg::BFPA_ADDR_W-1:0] awaddr,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [bfpa_pkg::BFPA_DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [bfpa_pkg::BFPA_ADDR_W-1:0] araddr,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [bfpa_pkg::BFPA_DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // core requests
   input wire logic storeReq,
   input wire logic loadReq,
   input wire logic [bfpa_pkg::BFPA_WORD_W-1:0] execAddr,
   input wire logic vectorsInLoader,
   // external programming port
   input wire logic extGuardWr,
   input wire logic [3:0] extGuardData,
   input wire logic extLockWr,
   input wire logic [1:0] extLockData,
   input wire logic extFuseWr,
   input wire logic extFuseData,
   input wire logic chipErase,
   // decisions and addresses
   output logic storeOk,
   output logic storeDenied,
   output logic loadOk,
   output logic loadDenied,
   output logic [bfpa_pkg::BFPA_PAGE_W-1:0] pageIndex,
   output logic [bfpa_pkg::BFPA_PAGE_WORD_W-1:0] wordInPageIndex,
   output logic [15:0] loadByteAddr,
   output logic byteSelectBit,
   output logic irqBlock,
   output logic [bfpa_pkg::BFPA_WORD_W-1:0] resetVector
);
   import bfpa_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [7:0] ptrLow; // flash_pointer_low
      logic [7:0] ptrHigh; // flash_pointer_high
      logic [7:0] ptrExt; // flash_pointer_extension
      logic [1:0] appField; // app_guard_field {high,low}
      logic [1:0] bootField; // boot_guard_field {high,low}
      logic [1:0] lockBits; // general lock bits, no effect here
      logic bootFuse; // boot_reset_select_fuse
      logic awHeld; // write address captured
      logic [7:0] awAddr;
      logic wHeld; // write data captured
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awRdy;
      logic wRdy;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic storeOk;
      logic storeDenied;
      logic loadOk;
      logic loadDenied;
      logic [BFPA_PAGE_W-1:0] page;
      logic [BFPA_PAGE_WORD_W-1:0] word;
      logic [15:0] loadAddr;
      logic byteSel;
      logic irqBlock;
      logic [BFPA_WORD_W-1:0] resetVec;
      logic [1:0] storeRes; // last self program result
      logic [1:0] loadRes; // last load result
   } bfpa_state_t;

   bfpa_state_t cur_ff; // registered state
   bfpa_state_t nxt_cur; // next state

   // ***************************************************
   // address and section decode
   // ***************************************************
   logic [23:0] zFull; // full pointer
   logic [BFPA_WORD_W-1:0] zWord; // word address of the pointer
   logic tgtLoader; // pointer targets loader_section
   logic execLoader; // executing code sits in loader_section
   logic storeAllow;
   logic loadAllow;
   logic irqMask;

   // pointer assembly; extension only meaningful on large parts
   always_comb begin
      zFull = {BFPA_HAS_EXT ? cur_ff.ptrExt : 8'h00, cur_ff.ptrHigh, cur_ff.ptrLow};
      zWord = zFull[BFPA_WORD_W:1];
      tgtLoader = (zWord >= BFPA_LOADER_START);
      execLoader = (execAddr >= BFPA_LOADER_START);
   end

   // access decisions; the general lock bits are never consulted
   always_comb begin
      storeAllow = execLoader;
      if (tgtLoader) begin
         // bit 0 programmed means modes 2 and 3
         storeAllow = storeAllow & cur_ff.bootField[0];
      end else begin
         storeAllow = storeAllow & cur_ff.appField[0];
      end
      loadAllow = 1'b1;
      if (tgtLoader && !execLoader) begin
         // bit 1 programmed means modes 3 and 4
         loadAllow = cur_ff.bootField[1];
      end else if (!tgtLoader && execLoader) begin
         loadAllow = cur_ff.appField[1];
      end
      // same-section reads stay open in every mode
      irqMask = (vectorsInLoader && !execLoader && !cur_ff.appField[1])
         || (!vectorsInLoader && execLoader && !cur_ff.bootField[1]);
   end

   // ***************************************************
   // next state
   // ***************************************************
   logic [31:0] rdMux;
   logic [1:0] rdResp;

   always_comb begin
      nxt_cur = cur_ff;
      rdMux = 32'h0000_0000;
      rdResp = BFPA_RESP_OKAY;
      // one-cycle decision pulses
      nxt_cur.storeOk = 1'b0;
      nxt_cur.storeDenied = 1'b0;
      nxt_cur.loadOk = 1'b0;
      nxt_cur.loadDenied = 1'b0;

      // write channels taken in either order
      if (awvalid && cur_ff.awRdy) begin
         nxt_cur.awHeld = 1'b1;
         nxt_cur.awAddr = awaddr;
      end
      if (wvalid && cur_ff.wRdy) begin
         nxt_cur.wHeld = 1'b1;
         nxt_cur.wData = wdata;
         nxt_cur.wStrb = wstrb;
      end
      // response retires
      if (cur_ff.bValid && bready) begin
         nxt_cur.bValid = 1'b0;
      end
      // register write once both halves are in and no response pends
      if (cur_ff.awHeld && cur_ff.wHeld && !cur_ff.bValid) begin
         nxt_cur.awHeld = 1'b0;
         nxt_cur.wHeld = 1'b0;
         nxt_cur.bValid = 1'b1;
         nxt_cur.bResp = BFPA_RESP_OKAY;
         case (cur_ff.awAddr)
            BFPA_OFF_PTR_LOW: begin
               if (cur_ff.wStrb[0]) nxt_cur.ptrLow = cur_ff.wData[7:0];
            end
            BFPA_OFF_PTR_HIGH: begin
               if (cur_ff.wStrb[0]) nxt_cur.ptrHigh = cur_ff.wData[7:0];
            end
            BFPA_OFF_PTR_EXT: begin
               if (cur_ff.wStrb[0]) nxt_cur.ptrExt = cur_ff.wData[7:0];
            end
            BFPA_OFF_GUARD: begin
               // software may only program bits (drive them to zero)
               if (cur_ff.wStrb[0]) begin
                  nxt_cur.appField = cur_ff.appField
                     & cur_ff.wData[BFPA_GUARD_APP_LSB +: 2];
                  nxt_cur.bootField = cur_ff.bootField
                     & cur_ff.wData[BFPA_GUARD_BOOT_LSB +: 2];
               end
            end
            BFPA_OFF_LOCK: begin
               if (cur_ff.wStrb[0]) nxt_cur.lockBits = cur_ff.lockBits & cur_ff.wData[1:0];
            end
            // status and captured address are read only; fuse has no core path
            BFPA_OFF_STATUS, BFPA_OFF_PROG_ADDR: begin
               nxt_cur.bResp = BFPA_RESP_OKAY;
            end
            default: begin
               nxt_cur.bResp = BFPA_RESP_DECERR;
            end
         endcase
      end

      // read decode
      case (araddr)
         BFPA_OFF_PTR_LOW: rdMux = {24'h000000, cur_ff.ptrLow};
         BFPA_OFF_PTR_HIGH: rdMux = {24'h000000, cur_ff.ptrHigh};
         BFPA_OFF_PTR_EXT: rdMux = {24'h000000, cur_ff.ptrExt};
         BFPA_OFF_GUARD: rdMux = {28'h0000000, cur_ff.bootField, cur_ff.appField};
         BFPA_OFF_LOCK: rdMux = {30'h0, cur_ff.lockBits};
         BFPA_OFF_STATUS: begin
            rdMux = {24'h000000, cur_ff.loadRes, cur_ff.storeRes, 3'h0, cur_ff.bootFuse};
         end
         BFPA_OFF_PROG_ADDR: rdMux = {17'h0, cur_ff.page, cur_ff.word};
         default: rdResp = BFPA_RESP_DECERR;
      endcase
      if (cur_ff.rValid && rready) begin
         nxt_cur.rValid = 1'b0;
      end
      if (arvalid && cur_ff.arRdy) begin
         nxt_cur.rValid = 1'b1;
         nxt_cur.rData = (rdResp == BFPA_RESP_OKAY) ? rdMux : 32'h0000_0000;
         nxt_cur.rResp = rdResp;
      end

      // self program: decide and latch the address at start
      if (storeReq) begin
         if (storeAllow) begin
            nxt_cur.storeOk = 1'b1;
            nxt_cur.storeRes = BFPA_RES_OK;
            // latched so the pointer is free during the operation
            nxt_cur.page = zWord[BFPA_WORD_W-1:BFPA_PAGE_WORD_W];
            nxt_cur.word = zWord[BFPA_PAGE_WORD_W-1:0];
         end else begin
            nxt_cur.storeDenied = 1'b1;
            nxt_cur.storeRes = BFPA_RES_DENIED;
         end
      end
      // program load: byte addressed, bit zero picks the byte
      if (loadReq) begin
         if (loadAllow) begin
            nxt_cur.loadOk = 1'b1;
            nxt_cur.loadRes = BFPA_RES_OK;
            nxt_cur.loadAddr = zFull[15:0];
            nxt_cur.byteSel = zFull[0];
         end else begin
            nxt_cur.loadDenied = 1'b1;
            nxt_cur.loadRes = BFPA_RES_DENIED;
         end
      end

      // external programming combines with software in the same cycle
      if (extGuardWr) begin
         nxt_cur.appField = nxt_cur.appField & extGuardData[BFPA_GUARD_APP_LSB +: 2];
         nxt_cur.bootField = nxt_cur.bootField & extGuardData[BFPA_GUARD_BOOT_LSB +: 2];
      end
      if (extLockWr) begin
         nxt_cur.lockBits = nxt_cur.lockBits & extLockData;
      end
      // chip erase is the only way back to unprogrammed
      if (chipErase) begin
         nxt_cur.appField = BFPA_FIELD_RST;
         nxt_cur.bootField = BFPA_FIELD_RST;
         nxt_cur.lockBits = BFPA_FIELD_RST;
      end
      // fuse moves only through the external port
      if (extFuseWr) begin
         nxt_cur.bootFuse = extFuseData;
      end

      // derived outputs
      nxt_cur.irqBlock = irqMask;
      nxt_cur.resetVec = cur_ff.bootFuse ? BFPA_APP_RESET : BFPA_LOADER_START;
      // ready flags: one transaction per direction at a time
      nxt_cur.awRdy = !nxt_cur.awHeld && !nxt_cur.bValid;
      nxt_cur.wRdy = !nxt_cur.wHeld && !nxt_cur.bValid;
      nxt_cur.arRdy = !nxt_cur.rValid;
   end

   // ***************************************************
   // state register
   // ***************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_ff <= '0;
         cur_ff.appField <= BFPA_FIELD_RST;
         cur_ff.bootField <= BFPA_FIELD_RST;
         cur_ff.lockBits <= BFPA_FIELD_RST;
         cur_ff.bootFuse <= BFPA_FUSE_RST;
         cur_ff.ptrLow <= BFPA_PTR_RST;
         cur_ff.ptrHigh <= BFPA_PTR_RST;
         cur_ff.ptrExt <= BFPA_PTR_RST;
         cur_ff.resetVec <= BFPA_APP_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign awready = cur_ff.awRdy;
   assign wready = cur_ff.wRdy;
   assign bvalid = cur_ff.bValid;
   assign bresp = cur_ff.bResp;
   assign arready = cur_ff.arRdy;
   assign rvalid = cur_ff.rValid;
   assign rdata = cur_ff.rData;
   assign rresp = cur_ff.rResp;
   assign storeOk = cur_ff.storeOk;
   assign storeDenied = cur_ff.storeDenied;
   assign loadOk = cur_ff.loadOk;
   assign loadDenied = cur_ff.loadDenied;
   assign pageIndex = cur_ff.page;
   assign wordInPageIndex = cur_ff.word;
   assign loadByteAddr = cur_ff.loadAddr;
   assign byteSelectBit = cur_ff.byteSel;
   assign irqBlock = cur_ff.irqBlock;
   assign resetVector = cur_ff.resetVec;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_store_from_app: assert property (storeReq && !execLoader |=> storeDenied && !storeOk)
      else $error("self program from app section was not refused");
   a_app_write_guard: assert property (storeReq && execLoader && !tgtLoader
      && !cur_ff.appField[0] |=> storeDenied)
      else $error("app write passed a programmed app guard");
   a_boot_write_guard: assert property (storeReq && execLoader && tgtLoader
      && !cur_ff.bootField[0] |=> storeDenied)
      else $error("loader write passed a programmed boot guard");
   a_open_store: assert property (storeReq && execLoader
      && (&cur_ff.appField) && (&cur_ff.bootField) |=> storeOk)
      else $error("unguarded self program was refused");
   a_app_read_guard: assert property (loadReq && execLoader && !tgtLoader
      && !cur_ff.appField[1] |=> loadDenied)
      else $error("loader read of app passed the app guard");
   a_boot_read_guard: assert property (loadReq && !execLoader && tgtLoader
      && !cur_ff.bootField[1] |=> loadDenied)
      else $error("app read of loader passed the boot guard");
   // checked against the pointer bytes, not the decode, so a wrong split shows up
   a_page_capture: assert property (storeOk |-> pageIndex == $past(cur_ff.ptrHigh)
      && wordInPageIndex == $past(cur_ff.ptrLow[7:1]))
      else $error("captured page or word differs from pointer");
   a_hold_capture: assert property (!storeOk ##1 !storeOk |-> $stable(pageIndex))
      else $error("captured page moved without a new operation");
   a_byte_select: assert property (loadOk |-> byteSelectBit == $past(cur_ff.ptrLow[0])
      && loadByteAddr == $past({cur_ff.ptrHigh, cur_ff.ptrLow}))
      else $error("byte select differs from pointer bit zero");
   a_guard_no_clear: assert property (!chipErase |=> ((cur_ff.appField
      & ~$past(cur_ff.appField)) == 2'h0))
      else $error("app guard bit cleared without chip erase");
   a_fuse_core: assert property (!extFuseWr |=> $stable(cur_ff.bootFuse))
      else $error("fuse changed without external programming");
   a_reset_vec: assert property (##1 resetVector == ($past(cur_ff.bootFuse)
      ? BFPA_APP_RESET : BFPA_LOADER_START))
      else $error("reset vector disagrees with fuse");
   a_irq_mask: assert property (vectorsInLoader && !execLoader && !cur_ff.appField[1]
      |=> irqBlock)
      else $error("interrupts left open in app with loader vectors");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");

   c_store_ok: cover property (storeReq ##1 storeOk);
   c_load_denied: cover property (loadReq ##1 loadDenied);
   c_chip_erase: cover property (!cur_ff.appField[0] ##1 chipErase ##1 cur_ff.appField[0]);
   c_axi_write: cover property (awvalid && wvalid ##[1:3] bvalid);
endmodule

// ===== tb/bfpa_core_model.sv
// Purpose: core model that issues self-program stores and program loads
// Assumes: requests are one-cycle pulses launched just after a clock edge
// Notes: execAddr and vectorsInLoader are levels held between calls
`timescale 1ns/1ps
module bfpa_core_model (
   // clock
   input wire logic clk,
   // request side
   output logic storeReq,
   output logic loadReq,
   output logic [bfpa_pkg::BFPA_WORD_W-1:0] execAddr,
   output logic vectorsInLoader
);
   import bfpa_pkg::*;
   // ***************************************************
   // request tasks
   // ***************************************************
   // idle core, running application code
   initial begin
      storeReq = 1'h0;
      loadReq = 1'h0;
      execAddr = 15'h0000;
      vectorsInLoader = 1'h0;
   end
   // one request pulse; a store when isStore, otherwise a load
   task automatic issue(input logic isStore, input logic [14:0] e);
      @(posedge clk);
      execAddr <= e;
      storeReq <= isStore;
      loadReq <= !isStore;
      @(posedge clk);
      storeReq <= 1'h0;
      loadReq <= 1'h0;
   endtask
   // move execution and vector placement without a request
   task automatic place(input logic [14:0] e, input logic v);
      @(posedge clk);
      execAddr <= e;
      vectorsInLoader <= v;
   endtask
endmodule

// ===== tb/bfpa_top_bench.sv
// Purpose: self-checking bench for the flash guard block
// Assumes: 20 MHz clock, asynchronous active-high reset
// Notes: lock bits stay programmed through the access matrix on purpose
`timescale 1ns/1ps
module bfpa_top_bench;
   import bfpa_pkg::*;
   // ***************************************************
   // signals
   // ***************************************************
   localparam logic [14:0] execApp = 15'h0040; // inside application section
   localparam logic [14:0] execLdr = 15'h7100; // inside loader_section
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, rsp, m;
   logic storeReq, loadReq, vectorsInLoader, storeOk, storeDenied, loadOk, loadDenied;
   logic extGuardWr = 1'h0, extLockWr = 1'h0, extFuseWr = 1'h0, extFuseData = 1'h1;
   logic chipErase = 1'h0, byteSelectBit, irqBlock;
   logic [3:0] extGuardData = 4'hF;
   logic [1:0] extLockData = 2'h3;
   logic [14:0] execAddr, resetVector;
   logic [BFPA_PAGE_W-1:0] pageIndex;
   logic [BFPA_PAGE_WORD_W-1:0] wordInPageIndex;
   logic [15:0] loadByteAddr;
   logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
   logic [31:0] rstVals [7] = '{32'h0, 32'h0, 32'h0, 32'hF, 32'h3, 32'h1, 32'h0};
   int n_errors = 0, checks_done = 0, cycles = 0;
   // ***************************************************
   // clock, watchdog, instances
   // ***************************************************
   always #25 clk = ~clk;
   // the whole run needs under three hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         give_verdict();
      end
   end
   bfpa_core_model i_core (.clk(clk), .storeReq(storeReq), .loadReq(loadReq),
      .execAddr(execAddr), .vectorsInLoader(vectorsInLoader));
   bfpa_top i_dut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .storeReq(storeReq), .loadReq(loadReq),
      .execAddr(execAddr), .vectorsInLoader(vectorsInLoader), .extGuardWr(extGuardWr),
      .extGuardData(extGuardData), .extLockWr(extLockWr), .extLockData(extLockData),
      .extFuseWr(extFuseWr), .extFuseData(extFuseData), .chipErase(chipErase),
      .storeOk(storeOk), .storeDenied(storeDenied), .loadOk(loadOk),
      .loadDenied(loadDenied), .pageIndex(pageIndex), .wordInPageIndex(wordInPageIndex),
      .loadByteAddr(loadByteAddr), .byteSelectBit(byteSelectBit), .irqBlock(irqBlock),
      .resetVector(resetVector));
   // ***************************************************
   // tasks
   // ***************************************************
   // single comparison, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // write: both halves offered together, each released once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw = 1'h0;
      logic w = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw = 1'h1;
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            w = 1'h1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'h1);
      r = bresp;
   endtask
   // read: address held until taken, data taken at the rvalid edge
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge clk); while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
   endtask
   // pointer bytes; the extension is left alone
   task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
      axi_wr(BFPA_OFF_PTR_HIGH, {24'h0, hi}, rsp);
      axi_wr(BFPA_OFF_PTR_LOW, {24'h0, lo}, rsp);
   endtask
   // erase, then program guards and both lock bits from the external port
   task automatic set_guard(input logic [3:0] g);
      @(posedge clk);
      chipErase <= 1'h1;
      @(posedge clk);
      chipErase <= 1'h0;
      extGuardWr <= 1'h1;
      extGuardData <= g;
      extLockWr <= 1'h1;
      extLockData <= 2'h0;
      @(posedge clk);
      extGuardWr <= 1'h0;
      extLockWr <= 1'h0;
   endtask
   // one request and its decision pulse a cycle later
   task automatic req(input logic st, input logic [14:0] e, input logic ok);
      i_core.issue(st, e);
      #1;
      chk(st ? {storeOk, storeDenied} : {loadOk, loadDenied}, {ok, !ok}, "decision");
   endtask
   // irq gate settles a cycle after the inputs move
   task automatic irq_at(input logic [14:0] e, input logic v, input logic exp);
      i_core.place(e, v);
      repeat (2) @(posedge clk);
      #1;
      chk(irqBlock, exp, "irq gate");
   endtask
   // closing report
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ***************************************************
   // sequence
   // ***************************************************
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk(resetVector, BFPA_APP_RESET, "vector");
      for (int i = 0; i < 7; i++) begin
         axi_rd(offs[i], rd, rsp);
         chk(rd, rstVals[i], "reset value");
      end
      axi_rd(8'h1C, rd, rsp);
      chk(rsp, BFPA_RESP_DECERR, "unmapped read");
      axi_wr(8'h20, 32'h0, rsp);
      chk(rsp, BFPA_RESP_DECERR, "unmapped write");
      // software may program guards but never unprogram them
      axi_wr(BFPA_OFF_GUARD, 32'h0, rsp);
      axi_wr(BFPA_OFF_GUARD, 32'hF, rsp);
      axi_rd(BFPA_OFF_GUARD, rd, rsp);
      chk(rd, 32'h0, "guard sticky");
      set_guard(4'hF);
      axi_rd(BFPA_OFF_GUARD, rd, rsp);
      chk(rd, 32'hF, "guard erased");
      // software cannot touch the fuse, the external port can
      axi_wr(BFPA_OFF_STATUS, 32'h0, rsp);
      axi_rd(BFPA_OFF_STATUS, rd, rsp);
      chk(rd & 32'h1, 32'h1, "fuse kept");
      @(posedge clk);
      extFuseWr <= 1'h1;
      extFuseData <= 1'h0;
      @(posedge clk);
      extFuseWr <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      chk(resetVector, BFPA_LOADER_START, "boot vector");
      // every mode of each field, with the lock bits programmed throughout
      for (int f = 0; f < 4; f++) begin
         m = f[1:0];
         set_guard({2'h3, m});
         set_ptr(8'h02, 8'h00);
         req(1'h1, execLdr, m[0]);
         req(1'h1, execApp, 1'h0);
         req(1'h0, execLdr, m[1]);
         req(1'h0, execApp, 1'h1);
         irq_at(execApp, 1'h1, !m[1]);
         set_guard({m, 2'h3});
         set_ptr(8'hE0, 8'h20);
         req(1'h1, execLdr, m[0]);
         req(1'h0, execApp, m[1]);
         req(1'h0, execLdr, 1'h1);
         irq_at(execLdr, 1'h0, !m[1]);
      end
      // address split, capture and byte addressing
      set_guard(4'hF);
      set_ptr(8'h9A, 8'h35);
      req(1'h1, execLdr, 1'h1);
      chk(pageIndex, 8'h9A, "page index");
      chk(wordInPageIndex, 7'h1A, "word in page");
      axi_wr(BFPA_OFF_PTR_EXT, 32'hFF, rsp);
      axi_wr(BFPA_OFF_PTR_HIGH, 32'h12, rsp);
      axi_rd(BFPA_OFF_PROG_ADDR, rd, rsp);
      chk(rd, 16'h9A35 >> 1, "capture kept");
      req(1'h0, execLdr, 1'h1);
      chk(loadByteAddr, 16'h1235, "load address");
      chk(byteSelectBit, 1'h1, "byte select");
      axi_wr(BFPA_OFF_PTR_LOW, 32'h34, rsp);
      req(1'h0, execLdr, 1'h1);
      chk(loadByteAddr, 16'h1234, "even load address");
      chk(byteSelectBit, 1'h0, "low byte select");
      req(1'h1, execLdr, 1'h1);
      chk({pageIndex, wordInPageIndex}, 16'h1235 >> 1, "no extension");
      give_verdict();
   end
endmodule
